//--- hw/cow_pkg.sv
// Purpose: Constants for the code option word decoder.
// Assumes: Option words are 13 bits wide, presented by the programming port.
// Notes: Field positions and word reset values are defined here; the bench repeats the positions as literals.
package cow_pkg;
   localparam int WORD_W = 13;
   localparam int CODE_W = 3;
   localparam int BIT_PERIOD = 8;
   localparam int BIT_WDOG_OFF = 7;
   localparam int BIT_RSVD_LO = 6;
   localparam int BIT_RANGE = 5;
   localparam int BIT_TYPE = 4;
   localparam int BIT_POWER = 3;
   localparam int BIT_PROT_HI = 2;
   localparam int BIT_RSVD_HI = 10;
   localparam logic [2:0] PROT_OFF_CODE = 3'h7;
   // Safe reset image: watchdog on, protection on, reserved bits one, all other bits zero.
   localparam logic [12:0] WORD0_RST = 13'h0440;
   localparam logic [12:0] WORD1_RST = 13'h0000;
   localparam logic [1:0] TMR_DIV2 = 2'h1;
   localparam logic [1:0] TMR_DIV4 = 2'h3;
   typedef enum logic [1:0] {
      COW_LOAD = 2'b00,
      COW_HOLD = 2'b01
   } cow_state_t;
   typedef enum logic [1:0] {
      COW_OSC_RC = 2'b00,
      COW_OSC_LXT = 2'b01,
      COW_OSC_HXT = 2'b11,
      COW_OSC_BAD = 2'b10
   } cow_osc_t;
endpackage

//--- hw/cow_decoder.sv
// Purpose: Capture and decode the two nonvolatile option words.
// Assumes: SRST is the power-on reset; option words are stable during it.
// Notes: Outputs are registered and frozen after the first cycle out of reset.

// Summary of operation
// (R1) Option bits are a separate store; the core has no read or write path.
// (R2) Two 13-bit words: word 0 configuration, word 1 customer identification.
// (R3) Word 0 bit 8 selects two (0) or four (1) clocks per instruction.
// (R4) Word 0 bit 7 low enables the watchdog, high disables it.
// (R5) Word 0 bit 5 selects low (0) or high (1) frequency crystal.
// (R6) Range bit matters only with crystal type; programmer keeps it zero else.
// (R7) Word 0 bit 4 selects RC (0) or crystal/resonator (1).
// (R8) Word 0 bit 3 selects low (0) or high (1) drive power.
// (R9) Bits 2..0 protect the code unless all ones.
// (R10) Bits 6 and 10 read as one; bits 12, 11, 9 have no effect.
// (R11) Word 1 is kept whole for the programmer and steers nothing.
// (R12) RC if type 0; high crystal if type and range 1; low if type 1 with range and power 0.
// (R13) Four-clock cycles give the timer a divide-by-four source, else two.
// (R14) Words are latched during power-on reset and held until next power-on.
module cow_decoder (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [cow_pkg::WORD_W-1:0] OPTION_WORD0,
   input wire logic [cow_pkg::WORD_W-1:0] OPTION_WORD1,
   output logic CONFIG_VALID,
   output logic INSTR_PERIOD_SELECT,
   output logic WATCHDOG_ENABLE,
   output logic CRYSTAL_FREQ_RANGE,
   output logic CLOCK_SOURCE_TYPE,
   output logic DRIVE_POWER_LEVEL,
   output logic RC_OSCILLATOR_MODE,
   output logic HIGH_CRYSTAL_MODE,
   output logic LOW_CRYSTAL_MODE,
   output logic [1:0] TIMER_COUNTER_DIV,
   output logic CODE_PROTECT_ACTIVE,
   output logic [cow_pkg::CODE_W-1:0] CODE_PROTECT_BITS,
   output logic [cow_pkg::WORD_W-1:0] PROG_WORD0_READBACK,
   output logic [cow_pkg::WORD_W-1:0] PROG_WORD1_READBACK
);
   import cow_pkg::*;

   cow_state_t state_ff, nxt_state;
   logic [WORD_W-1:0] word0_ff, nxt_word0;
   logic [WORD_W-1:0] word1_ff, nxt_word1;
   logic [WORD_W-1:0] w0;
   cow_osc_t osc_mode;

   // Reserved bits are forced to one whatever the programmer left there.
   function automatic logic [WORD_W-1:0] fix_reserved(
      input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] r;
      r = w;
      r[BIT_RSVD_LO] = 1'b1; // R10
      r[BIT_RSVD_HI] = 1'b1; // R10
      return r;
   endfunction

   function automatic cow_osc_t osc_decode(input logic [WORD_W-1:0] w);
      cow_osc_t m;
      if (!w[BIT_TYPE]) begin
         m = COW_OSC_RC; // R12 R7
      end else if (w[BIT_RANGE]) begin
         m = COW_OSC_HXT; // R12 R5 R6
      end else if (!w[BIT_POWER]) begin
         m = COW_OSC_LXT; // R12
      end else begin
         // Low range at high power has no defined mode; treated as neither.
         m = COW_OSC_BAD;
      end
      return m;
   endfunction

   // Loading repeats every cycle while reset is held, so the last value
   // before release is the one kept; the core never reaches these flops.
   always_comb begin
      nxt_state = state_ff;
      nxt_word0 = word0_ff;
      nxt_word1 = word1_ff;
      unique case (state_ff)
         COW_LOAD: begin
            nxt_state = COW_HOLD;
         end
         COW_HOLD: begin
            nxt_state = COW_HOLD; // R14
         end
         default: begin
            nxt_state = COW_LOAD;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_ff <= COW_LOAD;
         word0_ff <= fix_reserved(OPTION_WORD0); // R14 R1 R2
         word1_ff <= OPTION_WORD1; // R11 R2
      end else begin
         state_ff <= nxt_state;
         word0_ff <= nxt_word0; // R14
         word1_ff <= nxt_word1; // R14
      end
   end

   assign w0 = word0_ff;
   assign osc_mode = osc_decode(w0);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         CONFIG_VALID <= 1'b0;
         INSTR_PERIOD_SELECT <= WORD0_RST[BIT_PERIOD];
         WATCHDOG_ENABLE <= ~WORD0_RST[BIT_WDOG_OFF];
         CRYSTAL_FREQ_RANGE <= WORD0_RST[BIT_RANGE];
         CLOCK_SOURCE_TYPE <= WORD0_RST[BIT_TYPE];
         DRIVE_POWER_LEVEL <= WORD0_RST[BIT_POWER];
         RC_OSCILLATOR_MODE <= 1'b1;
         HIGH_CRYSTAL_MODE <= 1'b0;
         LOW_CRYSTAL_MODE <= 1'b0;
         TIMER_COUNTER_DIV <= TMR_DIV2;
         CODE_PROTECT_ACTIVE <= 1'b1;
         CODE_PROTECT_BITS <= WORD0_RST[BIT_PROT_HI:0];
         PROG_WORD0_READBACK <= WORD0_RST;
         PROG_WORD1_READBACK <= WORD1_RST;
      end else begin
         CONFIG_VALID <= 1'b1;
         INSTR_PERIOD_SELECT <= w0[BIT_PERIOD]; // R3
         WATCHDOG_ENABLE <= ~w0[BIT_WDOG_OFF]; // R4
         CRYSTAL_FREQ_RANGE <= w0[BIT_RANGE]; // R5
         CLOCK_SOURCE_TYPE <= w0[BIT_TYPE]; // R7
         DRIVE_POWER_LEVEL <= w0[BIT_POWER]; // R8
         RC_OSCILLATOR_MODE <= (osc_mode == COW_OSC_RC); // R12
         HIGH_CRYSTAL_MODE <= (osc_mode == COW_OSC_HXT); // R12
         LOW_CRYSTAL_MODE <= (osc_mode == COW_OSC_LXT); // R12
         TIMER_COUNTER_DIV <= w0[BIT_PERIOD] ? TMR_DIV4 : TMR_DIV2; // R13
         CODE_PROTECT_ACTIVE <=
            (w0[BIT_PROT_HI:0] != PROT_OFF_CODE); // R9
         CODE_PROTECT_BITS <= w0[BIT_PROT_HI:0]; // R9
         PROG_WORD0_READBACK <= w0; // R10
         PROG_WORD1_READBACK <= word1_ff; // R11
      end
   end

   a_words_frozen: assert property (@(posedge CLK) disable iff (SRST)
      $stable(word0_ff) && $stable(word1_ff)) // R14
      else $error("Option words changed after reset release.");

   a_rsvd_ones: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> PROG_WORD0_READBACK[BIT_RSVD_LO]
      && PROG_WORD0_READBACK[BIT_RSVD_HI]) // R10
      else $error("Reserved option bits not one.");

   a_period_div: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> (TIMER_COUNTER_DIV ==
      (INSTR_PERIOD_SELECT ? TMR_DIV4 : TMR_DIV2))) // R13
      else $error("Timer divider does not follow instruction period.");

   a_period_bit: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> INSTR_PERIOD_SELECT == word0_ff[BIT_PERIOD]) // R3
      else $error("Instruction period differs from word.");

   a_wdog_low: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> WATCHDOG_ENABLE != word0_ff[BIT_WDOG_OFF]) // R4
      else $error("Watchdog enable polarity wrong.");

   a_rc_mode: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> RC_OSCILLATOR_MODE == !CLOCK_SOURCE_TYPE) // R12
      else $error("RC mode does not follow oscillator type.");

   a_hxt_mode: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> HIGH_CRYSTAL_MODE ==
      (CLOCK_SOURCE_TYPE && CRYSTAL_FREQ_RANGE)) // R12
      else $error("High crystal mode wrong.");

   a_lxt_mode: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> LOW_CRYSTAL_MODE == (CLOCK_SOURCE_TYPE &&
      !CRYSTAL_FREQ_RANGE && !DRIVE_POWER_LEVEL)) // R12
      else $error("Low crystal mode wrong.");

   a_protect_code: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> CODE_PROTECT_ACTIVE ==
      (CODE_PROTECT_BITS != PROT_OFF_CODE)) // R9
      else $error("Protection state wrong.");

   a_valid_rise: assert property (@(posedge CLK)
      $fell(SRST) |-> ##1 CONFIG_VALID) // R14
      else $error("Configuration not valid one cycle after reset.");

   // Reset seen high on two edges in a row, so the safe image has landed.
   sequence s_reset_held;
      SRST ##1 SRST;
   endsequence

   // Reset seen high and then low, so the captured words are being decoded.
   sequence s_reset_release;
      SRST ##1 !SRST;
   endsequence

   // The decoded words are on the outputs and the loader has settled.
   sequence s_config_shown;
      CONFIG_VALID && (state_ff == COW_HOLD);
   endsequence

   // Safe image: watchdog on and protection on until the words are known.
   sequence s_safe_image;
      !CONFIG_VALID && WATCHDOG_ENABLE && CODE_PROTECT_ACTIVE
      && RC_OSCILLATOR_MODE && !HIGH_CRYSTAL_MODE && !LOW_CRYSTAL_MODE;
   endsequence

   a_release_show: assert property (@(posedge CLK)
      s_reset_release |-> ##1 s_config_shown) // R14
      else $error("Decoded words not shown after reset release.");

   a_reset_image: assert property (@(posedge CLK)
      s_reset_held |-> s_safe_image) // R14
      else $error("Safe image not shown during reset.");

   a_reset_words: assert property (@(posedge CLK)
      s_reset_held |-> TIMER_COUNTER_DIV == TMR_DIV2
      && PROG_WORD0_READBACK == WORD0_RST
      && PROG_WORD1_READBACK == WORD1_RST) // R14
      else $error("Reset divider or readback image wrong.");

   // Codes 10 and 11 of the loader state are never reached.
   a_state_legal: assert property (@(posedge CLK) disable iff (SRST)
      state_ff == COW_LOAD || state_ff == COW_HOLD) // R14
      else $error("Loader state left its legal codes.");

   a_valid_state: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> state_ff == COW_HOLD) // R14
      else $error("Configuration valid while loader not holding.");

   a_range_bit: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> CRYSTAL_FREQ_RANGE == word0_ff[BIT_RANGE]) // R5
      else $error("Crystal range differs from word.");

   a_type_bit: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> CLOCK_SOURCE_TYPE == word0_ff[BIT_TYPE]) // R7
      else $error("Oscillator type differs from word.");

   a_power_bit: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> DRIVE_POWER_LEVEL == word0_ff[BIT_POWER]) // R8
      else $error("Drive power differs from word.");

   a_prot_bits: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |->
      CODE_PROTECT_BITS == word0_ff[BIT_PROT_HI:0]) // R9
      else $error("Protection bits differ from word.");

   a_prot_off: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID && word0_ff[BIT_PROT_HI:0] == PROT_OFF_CODE
      |-> !CODE_PROTECT_ACTIVE) // R9
      else $error("Protection active with the all-ones code.");

   a_word0_copy: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> PROG_WORD0_READBACK == word0_ff) // R10
      else $error("Word 0 readback differs from store.");

   a_rsvd_store: assert property (@(posedge CLK) disable iff (SRST)
      word0_ff[BIT_RSVD_LO] && word0_ff[BIT_RSVD_HI]) // R10
      else $error("Stored reserved bits not one.");

   a_word1_copy: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> PROG_WORD1_READBACK == word1_ff) // R11
      else $error("Word 1 readback differs from store.");

   a_mode_onehot: assert property (@(posedge CLK) disable iff (SRST)
      $onehot0({RC_OSCILLATOR_MODE, HIGH_CRYSTAL_MODE,
      LOW_CRYSTAL_MODE})) // R12
      else $error("More than one oscillator mode active.");

   // Low range at high power is left without a mode on purpose.
   a_mode_gap: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID && CLOCK_SOURCE_TYPE && !CRYSTAL_FREQ_RANGE
      && DRIVE_POWER_LEVEL |-> !RC_OSCILLATOR_MODE
      && !HIGH_CRYSTAL_MODE && !LOW_CRYSTAL_MODE) // R12
      else $error("Mode given for undefined oscillator setting.");

   a_hxt_word: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> HIGH_CRYSTAL_MODE ==
      (word0_ff[BIT_TYPE] && word0_ff[BIT_RANGE])) // R12
      else $error("High crystal mode differs from word.");

   a_lxt_word: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID |-> LOW_CRYSTAL_MODE == (word0_ff[BIT_TYPE]
      && !word0_ff[BIT_RANGE] && !word0_ff[BIT_POWER])) // R12
      else $error("Low crystal mode differs from word.");

   a_div_codes: assert property (@(posedge CLK) disable iff (SRST)
      TIMER_COUNTER_DIV == TMR_DIV2 || TIMER_COUNTER_DIV == TMR_DIV4) // R13
      else $error("Timer divider code outside its two values.");

   // The first valid cycle follows the reset image, so it is skipped here.
   a_out_frozen: assert property (@(posedge CLK) disable iff (SRST)
      CONFIG_VALID && $past(CONFIG_VALID) |->
      $stable(PROG_WORD0_READBACK) && $stable(PROG_WORD1_READBACK)
      && $stable(TIMER_COUNTER_DIV)) // R1
      else $error("Configuration outputs changed while running.");
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the option word decoder.
// Assumes: SRST is the power-on reset, so each word set is loaded by a reset.
// Notes: Word 0 keeps range at zero while type is zero.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cow_pkg::*;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic [WORD_W-1:0] w0 = 13'h0000;
   logic [WORD_W-1:0] w1 = 13'h0000;
   logic vld, per, wd, rng, typ, pwr, rc, hx, lx, pact;
   logic [1:0] div;
   logic [2:0] pbits;
   logic [12:0] rb0, rb1;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   always #20 CLK = ~CLK;
   cow_decoder u_dut (.CLK(CLK), .SRST(SRST), .OPTION_WORD0(w0),
      .OPTION_WORD1(w1), .CONFIG_VALID(vld), .INSTR_PERIOD_SELECT(per),
      .WATCHDOG_ENABLE(wd), .CRYSTAL_FREQ_RANGE(rng),
      .CLOCK_SOURCE_TYPE(typ), .DRIVE_POWER_LEVEL(pwr),
      .RC_OSCILLATOR_MODE(rc), .HIGH_CRYSTAL_MODE(hx),
      .LOW_CRYSTAL_MODE(lx), .TIMER_COUNTER_DIV(div),
      .CODE_PROTECT_ACTIVE(pact), .CODE_PROTECT_BITS(pbits),
      .PROG_WORD0_READBACK(rb0), .PROG_WORD1_READBACK(rb1));
   task automatic check(string name, logic [12:0] seen, logic [12:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // A hang would otherwise leave the run open forever.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic load(logic [12:0] a, logic [12:0] b);
      @(posedge CLK);
      SRST <= 1'b1;
      w0 <= a;
      w1 <= b;
      repeat (2) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      #1;
   endtask
   task automatic expect_cfg(logic [12:0] a, logic [12:0] b);
      check("valid", vld, 1'b1);
      check("period", per, a[8]);
      check("div", div, a[8] ? TMR_DIV4 : TMR_DIV2);
      check("wdog", wd, !a[7]);
      check("range", rng, a[5]);
      check("type", typ, a[4]);
      check("power", pwr, a[3]);
      check("rc", rc, !a[4]);
      check("hxt", hx, a[4] & a[5]);
      check("lxt", lx, a[4] & !a[5] & !a[3]);
      check("prot", pact, a[2:0] != 3'h7);
      check("pbits", pbits, a[2:0]);
      check("rb0", rb0, a | 13'h0440);
      check("rb1", rb1, b);
   endtask
   task automatic reset_image();
      @(posedge CLK);
      SRST <= 1'b1;
      w0 <= 13'h1FFF;
      w1 <= 13'h1ABC;
      repeat (2) @(posedge CLK);
      #1;
      check("valid", vld, 1'b0);
      check("rc", rc, 1'b1);
      check("wdog", wd, 1'b1);
      check("prot", pact, 1'b1);
      check("div", div, TMR_DIV2);
      check("rb0", rb0, WORD0_RST);
      check("rb1", rb1, WORD1_RST);
   endtask
   task automatic decode_table();
      logic [12:0] words [6] = '{13'h0000, 13'h1FFF, 13'h0010, 13'h0018,
         13'h0130, 13'h1A8F};
      foreach (words[k]) begin
         load(words[k], ~words[k]);
         expect_cfg(words[k], ~words[k]);
      end
      for (int i = 0; i < 8; i++) begin
         load(13'(i) | 13'(i << 7), 13'(i));
         expect_cfg(13'(i) | 13'(i << 7), 13'(i));
      end
   endtask
   // Word changes after release must not reach the outputs.
   task automatic hold_after_load();
      load(13'h0137, 13'h0555);
      w0 <= 13'h1EC8;
      w1 <= 13'h1AAA;
      repeat (3) @(posedge CLK);
      #1;
      expect_cfg(13'h0137, 13'h0555);
   endtask
   initial begin
      repeat (4) @(posedge CLK);
      reset_image();
      decode_table();
      hold_after_load();
      complete_run();
   end
endmodule
